//--- dv/sdr_regs_asserts.sv
// Port-level checker for the serial data/status register block.
// Assumes it is bound to sdr_regs and sees only that module's ports.
`timescale 1ns/1ps
module sdr_regs_asserts (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic irq, // Interrupt
  input wire logic sck_in, // Clock in
  input wire logic sck_out, // Clock out
  input wire logic sck_oe, // Clock enable
  input wire logic mosi_in, // Out line in
  input wire logic mosi_out, // Out line out
  input wire logic mosi_oe, // Out line enable
  input wire logic miso_in, // In line in
  input wire logic miso_out, // In line out
  input wire logic miso_oe, // In line enable
  input wire logic ss_n_in, // Select pin
  input wire logic ss_pin_released // Pin freed
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  logic od_sh;
  logic ie_sh;
  logic [10:0] since_wr;
  wire csr_wr = reg_wr && reg_addr == sdr_pkg::ADDR_CSR;
  // Shadows of software-written bits, since the checker cannot see the registers
  always_ff @(posedge core_clk or posedge rst)
    if (rst) od_sh <= 1'b0;
    else if (csr_wr) od_sh <= reg_wdata[sdr_pkg::CSR_OUT_DIS];
  always_ff @(posedge core_clk or posedge rst)
    if (rst) ie_sh <= 1'b0;
    else if (reg_wr && reg_addr == sdr_pkg::ADDR_CTRL) ie_sh <= reg_wdata[sdr_pkg::CTRL_IRQ_EN];
  // Saturates so the slowest rate still fits under the bound
  always_ff @(posedge core_clk or posedge rst)
    if (rst) since_wr <= 11'h000;
    else if (reg_wr && reg_addr == sdr_pkg::ADDR_DATA) since_wr <= 11'h000;
    else if (since_wr != 11'h7ff) since_wr <= since_wr + 11'h001;

  csr_reserved_a: assert property (
    reg_rd && reg_addr == sdr_pkg::ADDR_CSR |=> reg_rdata[3] == 1'b0)
    else $error("reserved status bit read as one");
  fault_drop_a: assert property (
    (sck_oe && !ss_pin_released && !ss_n_in) [*3] |-> ##[0:3] !sck_oe)
    else $error("master kept after select fault");
  fault_irq_a: assert property (
    (sck_oe && !ss_pin_released && !ss_n_in && ie_sh) [*3] |-> ##[0:3] irq)
    else $error("no interrupt on mode fault");
  out_disable_a: assert property (
    od_sh && $past(od_sh) |-> !mosi_oe && !miso_oe)
    else $error("data output driven while disabled");
  out_excl_a: assert property (
    mosi_oe |-> sck_oe && !miso_oe)
    else $error("wrong data output enabled");
  sel_release_a: assert property (
    csr_wr |=> ss_pin_released == $past(reg_wdata[sdr_pkg::CSR_SEL_MGMT]))
    else $error("select pin release not following bit");
  unmapped_zero_a: assert property (
    reg_rd && !(reg_addr inside {8'h31, 8'h32, 8'h33, 8'h3e, 8'h3f}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  sck_start_a: assert property (
    $changed(sck_out) && $stable(sck_oe) && sck_oe && !$past(reg_wr) |-> since_wr < 11'd1200)
    else $error("serial clock runs without data write");
endmodule

//--- dv/sdr_spi_peer.sv
// Behavioural far-end serial slave: clock idle low, samples on rising edges.
// Assumes the master drives sck and mosi; miso means something only while selected.
`timescale 1ns/1ps
module sdr_spi_peer (
  input wire logic sck, // Serial clock from master
  input wire logic mosi, // Data from master
  input wire logic sel_n, // Select, active low
  input wire logic [7:0] tx_byte, // Byte to return
  output logic miso, // Data to master
  output logic [7:0] rx_byte // Bytes collected, MSB first
);
  logic [7:0] sr = 8'h00;
  logic last = 1'b0;
  initial rx_byte = 8'h00;
  always @(negedge sel_n) sr = tx_byte;
  always @(posedge sel_n) last = sr[7];
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) sr = {sr[6:0], 1'b0};
  // Released line shows the inverse of its last bit, never a stale copy
  assign miso = sel_n ? ~last : sr[7];
endmodule

//--- dv/tb.sv
// Self-checking bench for the serial data/status register block.
// Assumes the slave model and checker are compiled before this file.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ss_n_in = 1'b1;
  logic peer_sel_n = 1'b1, link_sck = 1'b0, link_mosi = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, peer_tx = 8'h00;
  logic [7:0] reg_rdata, peer_rx, got;
  logic irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_pin_released, peer_miso;
  int num_errors = 0, total_checks = 0, sck_rises = 0;
  wire sck_w = sck_oe ? sck_out : link_sck;
  wire mosi_w = mosi_oe ? mosi_out : link_mosi;
  wire miso_w = miso_oe ? miso_out : peer_miso;
  sdr_regs u_sdr_regs (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in),
    .ss_pin_released(ss_pin_released));
  sdr_spi_peer u_sdr_spi_peer (.sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n), .tx_byte(peer_tx),
    .miso(peer_miso), .rx_byte(peer_rx));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge sck_out) sck_rises++;

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Every bus task returns 1 ns after an edge, so later samples never race it
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk(got, e);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) cyc(1);
    chk({7'h00, irq}, 8'h01);
    if (irq !== 1'b1) wrap_up();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic [7:0] rx, input logic [7:0] old);
    int n;
    peer_sel_n <= 1'b1;
    cyc(2);
    peer_tx <= rx;
    peer_sel_n <= 1'b0;
    n = sck_rises;
    wr(8'h31, tx);
    cyc(30);
    rdc(8'h31, old);
    wait_irq();
    chk(peer_rx, tx);
    chk(8'(sck_rises - n), 8'h08);
  endtask
  // One byte as link master on an 800 ns clock, idle low, then time for the done pulse
  task automatic slave_byte(input logic [7:0] s, output logic [7:0] m);
    for (int i = 7; i >= 0; i--) begin
      link_mosi = s[i];
      #400 link_sck = 1'b1;
      m[i] = miso_w;
      #400 link_sck = 1'b0;
    end
    cyc(8);
  endtask
  task automatic done_seq(input logic [7:0] rx);
    rdc(8'h33, 8'h80);
    rdc(8'h31, rx);
    rdc(8'h33, 8'h00);
  endtask

  task automatic t_reset();
    rdc(8'h32, 8'h00);
    rdc(8'h33, 8'h00);
    rdc(8'h30, 8'h00);
    rdc(8'h3f, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_csr();
    wr(8'h33, 8'hf7);
    rdc(8'h33, 8'h07);
    chk({7'h00, ss_pin_released}, 8'h01);
    wr(8'h33, 8'h00);
    $display("t_csr done");
  endtask
  task automatic t_xfer();
    int n;
    wr(8'h32, 8'hd0);
    xfer(8'ha5, 8'h3c, 8'h00);
    n = sck_rises;
    wr(8'h31, 8'h11);
    cyc(20);
    chk(8'(sck_rises - n), 8'h00);
    done_seq(8'h3c);
    xfer(8'h5a, 8'h96, 8'h3c);
    done_seq(8'h96);
    $display("t_xfer done");
  endtask
  task automatic t_irq();
    wr(8'h32, 8'h50);
    wr(8'h3f, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(8'h3f, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rdc(8'h3e, 8'h01);
    wr(8'h3e, 8'h01);
    chk({7'h00, irq}, 8'h00);
    wr(8'h3f, 8'h00);
    $display("t_irq done");
  endtask
  // Bench acts as master on an 800 ns link clock, idle low
  task automatic t_slave();
    logic [7:0] m;
    logic [7:0] s;
    s = 8'h69;
    wr(8'h32, 8'hc0);
    wr(8'h31, 8'hc3);
    ss_n_in <= 1'b0;
    #337;
    slave_byte(s, m);
    wait_irq();
    chk(m, 8'hc3);
    // Second byte completes with the transfer flag still set
    slave_byte(8'h1e, m);
    ss_n_in <= 1'b1;
    rdc(8'h33, 8'ha0);
    rdc(8'h31, 8'h69);
    rdc(8'h33, 8'h00);
    wr(8'h32, 8'h00);
    $display("t_slave done");
  endtask
  task automatic t_od();
    wr(8'h32, 8'h50);
    chk({6'h00, mosi_oe, miso_oe}, 8'h02);
    wr(8'h33, 8'h04);
    chk({6'h00, mosi_oe, miso_oe}, 8'h00);
    wr(8'h32, 8'h40);
    ss_n_in <= 1'b0;
    cyc(4);
    chk({6'h00, mosi_oe, miso_oe}, 8'h00);
    wr(8'h33, 8'h00);
    chk({6'h00, mosi_oe, miso_oe}, 8'h01);
    wr(8'h32, 8'h00);
    ss_n_in <= 1'b1;
    $display("t_od done");
  endtask
  task automatic t_mode_fault_flag();
    wr(8'h32, 8'hd0);
    ss_n_in <= 1'b0;
    cyc(6);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, sck_oe}, 8'h00);
    rdc(8'h32, 8'h80);
    ss_n_in <= 1'b1;
    wr(8'h32, 8'h80);
    rdc(8'h33, 8'h10);
    wr(8'h32, 8'h80);
    rdc(8'h33, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("t_mode_fault_flag done");
  endtask
  task automatic t_ssm();
    wr(8'h33, 8'h03);
    ss_n_in <= 1'b0;
    wr(8'h32, 8'h50);
    cyc(6);
    chk({7'h00, sck_oe}, 8'h01);
    wr(8'h33, 8'h02);
    cyc(3);
    chk({7'h00, sck_oe}, 8'h00);
    rdc(8'h33, 8'h12);
    wr(8'h32, 8'h00);
    wr(8'h33, 8'h00);
    ss_n_in <= 1'b1;
    $display("t_ssm done");
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_csr();
    t_xfer();
    t_irq();
    t_slave();
    t_od();
    t_mode_fault_flag();
    t_ssm();
    wrap_up();
  end
endmodule

bind sdr_regs sdr_regs_asserts u_sdr_regs_asserts (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
  .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
  .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n_in), .ss_pin_released(ss_pin_released));

//--- hdl/sdr_pkg.sv
// Shared constants for the serial data/status register block.
// Assumes an 8-bit register port with byte-wide data.
package sdr_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int RATE_W = 3;
  localparam int HALF_W = 7;
  localparam int IRQ_W = 3;
  localparam int SYNC_W = 4;
  localparam int BIT_CNT_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h32;
  localparam logic [ADDR_W-1:0] ADDR_CSR = 8'h33;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h3e;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h3f;

  // Control register fields
  localparam int CTRL_IRQ_EN = 7;
  localparam int CTRL_PERIPH_EN = 6;
  localparam int CTRL_DIV_EN = 5;
  localparam int CTRL_MASTER = 4;
  localparam int CTRL_CPOL = 3;
  localparam int CTRL_CPHA = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;

  // Control/status register fields
  localparam int CSR_XFER_DONE = 7;
  localparam int CSR_WRITE_COLLISION_FLAG = 6;
  localparam int CSR_OVERRUN = 5;
  localparam int CSR_MODE_FAULT = 4;
  localparam int CSR_RESERVED = 3;
  localparam int CSR_OUT_DIS = 2;
  localparam int CSR_SEL_MGMT = 1;
  localparam int CSR_INT_SEL = 0;
  localparam int CSR_CFG_W = 3;

  // Interrupt status/mask fields
  localparam int IRQ_XFER = 0;
  localparam int IRQ_MODE_FAULT_FLAG = 1;
  localparam int IRQ_OVR = 2;

  // Pin synchroniser lanes
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS_N = 3;

  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [CSR_CFG_W-1:0] CSR_CFG_RESET = 3'h0;
  localparam logic [DATA_W-1:0] RX_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [BIT_CNT_W-1:0] LAST_EDGE = 4'hf;

  // Master clock rate codes {divider_enable, rate_select_hi, rate_select_lo}
  localparam logic [RATE_W-1:0] RATE_DIV4 = 3'h4;
  localparam logic [RATE_W-1:0] RATE_DIV8 = 3'h0;
  localparam logic [RATE_W-1:0] RATE_DIV16 = 3'h1;
  localparam logic [RATE_W-1:0] RATE_DIV32 = 3'h6;
  localparam logic [RATE_W-1:0] RATE_DIV64 = 3'h2;
  localparam logic [RATE_W-1:0] RATE_DIV128 = 3'h3;

  // Half serial clock periods in core cycles
  function automatic logic [HALF_W-1:0] half_period(input logic [RATE_W-1:0] rate);
    logic [HALF_W-1:0] h;
    h = 7'h40;
    case (rate)
      RATE_DIV4: h = 7'h02;
      RATE_DIV8: h = 7'h04;
      RATE_DIV16: h = 7'h08;
      RATE_DIV32: h = 7'h10;
      RATE_DIV64: h = 7'h20;
      RATE_DIV128: h = 7'h40;
      default: h = 7'h40;
    endcase
    return h;
  endfunction
endpackage

//--- hdl/sdr_regs.sv
// Register file, flag clearing sequences and pin control of the serial port.
// Assumes a single-cycle register port and external pins on foreign timing.
`timescale 1ns/1ps
module sdr_regs (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic [sdr_pkg::ADDR_W-1:0] reg_addr, // Register address
  input wire logic [sdr_pkg::DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [sdr_pkg::DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  output logic irq, // Interrupt request level
  input wire logic sck_in, // Serial clock pin in
  output logic sck_out, // Serial clock pin out
  output logic sck_oe, // Serial clock drive enable
  input wire logic mosi_in, // Master-out line in
  output logic mosi_out, // Master-out line out
  output logic mosi_oe, // Master-out drive enable
  input wire logic miso_in, // Slave-out line in
  output logic miso_out, // Slave-out line out
  output logic miso_oe, // Slave-out drive enable
  input wire logic ss_n_in, // Slave select pin, active low
  output logic ss_pin_released // Select pin free for general use
);
  logic [sdr_pkg::SYNC_W-1:0] pins_raw;
  logic [sdr_pkg::SYNC_W-1:0] sync1;
  logic [sdr_pkg::SYNC_W-1:0] sync2;
  logic [sdr_pkg::DATA_W-1:0] ctrl;
  logic [sdr_pkg::CSR_CFG_W-1:0] csr_cfg;
  logic [sdr_pkg::DATA_W-1:0] rx_buf;
  logic [sdr_pkg::DATA_W-1:0] rx_byte;
  logic [sdr_pkg::IRQ_W-1:0] irq_status;
  logic [sdr_pkg::IRQ_W-1:0] irq_mask;
  logic [sdr_pkg::IRQ_W-1:0] irq_event;
  logic xfer_done_flag;
  logic write_collision_flag;
  logic overrun_flag;
  logic mode_fault_flag;
  logic status_seen;
  logic mode_fault_flag_armed;
  logic ss_level;
  logic selected;
  logic master_select;
  logic peripheral_enable;
  logic output_disable;
  logic busy;
  logic done;
  logic ser_out;
  logic sck_level;
  logic sel_data;
  logic sel_ctrl;
  logic sel_csr;
  logic rd_csr;
  logic wr_data;
  logic wr_ctrl;
  logic data_access;
  logic wr_open;
  logic load;
  logic clr_xfer;
  logic overrun_now;
  logic fault_now;

  // Two flops per pin before any logic looks at it
  assign pins_raw = {ss_n_in, miso_in, mosi_in, sck_in};
  genvar gi;
  generate
    for (gi = 0; gi < sdr_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pins_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  assign sel_data = reg_addr == sdr_pkg::ADDR_DATA;
  assign sel_ctrl = reg_addr == sdr_pkg::ADDR_CTRL;
  assign sel_csr = reg_addr == sdr_pkg::ADDR_CSR;
  assign rd_csr = reg_rd & sel_csr;
  assign wr_data = reg_wr & sel_data;
  assign wr_ctrl = reg_wr & sel_ctrl;
  assign data_access = (reg_wr | reg_rd) & sel_data;

  assign master_select = ctrl[sdr_pkg::CTRL_MASTER];
  assign peripheral_enable = ctrl[sdr_pkg::CTRL_PERIPH_EN];
  assign output_disable = csr_cfg[sdr_pkg::CSR_OUT_DIS];
  assign ss_level = csr_cfg[sdr_pkg::CSR_SEL_MGMT] ? csr_cfg[sdr_pkg::CSR_INT_SEL] : sync2[sdr_pkg::PIN_SS_N];
  assign selected = ~ss_level;
  assign ss_pin_released = csr_cfg[sdr_pkg::CSR_SEL_MGMT];

  assign fault_now = master_select & ~ss_level;
  assign wr_open = ~xfer_done_flag | status_seen;
  assign load = wr_data & wr_open & ~busy & peripheral_enable;
  assign clr_xfer = data_access & status_seen;
  assign overrun_now = done & xfer_done_flag & ~clr_xfer;

  sdr_shift u_shift (
    .core_clk(core_clk),
    .rst(rst),
    .enable(peripheral_enable),
    .master(master_select),
    .cpol(ctrl[sdr_pkg::CTRL_CPOL]),
    .cpha(ctrl[sdr_pkg::CTRL_CPHA]),
    .rate({ctrl[sdr_pkg::CTRL_DIV_EN], ctrl[sdr_pkg::CTRL_RATE_HI], ctrl[sdr_pkg::CTRL_RATE_LO]}),
    .load(load),
    .load_data(reg_wdata),
    .sck_sync(sync2[sdr_pkg::PIN_SCK]),
    .rx_sync(master_select ? sync2[sdr_pkg::PIN_MISO] : sync2[sdr_pkg::PIN_MOSI]),
    .selected(selected),
    .sck_level(sck_level),
    .ser_out(ser_out),
    .rx_byte(rx_byte),
    .busy(busy),
    .done(done)
  );

  // Pin drive; output disable only masks the data line
  assign sck_out = sck_level;
  assign sck_oe = peripheral_enable & master_select;
  assign mosi_out = ser_out;
  assign mosi_oe = peripheral_enable & master_select & ~output_disable;
  assign miso_out = ser_out;
  assign miso_oe = peripheral_enable & ~master_select & selected & ~output_disable;

  // Control register; a fault overrides a same-cycle write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl <= sdr_pkg::CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= reg_wdata;
      end
      if (fault_now) begin
        ctrl[sdr_pkg::CTRL_PERIPH_EN] <= 1'b0;
        ctrl[sdr_pkg::CTRL_MASTER] <= 1'b0;
      end
    end
  end

  // Only the low configuration bits of the status register are writable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      csr_cfg <= sdr_pkg::CSR_CFG_RESET;
    end else if (reg_wr & sel_csr) begin
      csr_cfg <= reg_wdata[sdr_pkg::CSR_CFG_W-1:0];
    end
  end

  // Clearing sequence memory, used up by the next data or control access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_seen <= 1'b0;
      mode_fault_flag_armed <= 1'b0;
    end else if (rd_csr) begin
      status_seen <= 1'b1;
      mode_fault_flag_armed <= mode_fault_flag;
    end else if (data_access | ((reg_wr | reg_rd) & sel_ctrl)) begin
      status_seen <= 1'b0;
      mode_fault_flag_armed <= 1'b0;
    end
  end

  // Hardware set wins over the software clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      xfer_done_flag <= 1'b0;
      write_collision_flag <= 1'b0;
    end else begin
      xfer_done_flag <= done | (xfer_done_flag & ~clr_xfer);
      write_collision_flag <= (wr_data & wr_open & busy) | (write_collision_flag & ~clr_xfer);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      overrun_flag <= 1'b0;
    end else begin
      overrun_flag <= overrun_now | (overrun_flag & ~rd_csr);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_fault_flag <= 1'b0;
    end else begin
      mode_fault_flag <= fault_now | (mode_fault_flag & ~(wr_ctrl & mode_fault_flag_armed));
    end
  end

  // Receive buffer keeps the unread byte on overrun
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_buf <= sdr_pkg::RX_RESET;
    end else if (done & ~overrun_now) begin
      rx_buf <= rx_byte;
    end
  end

  // Sticky event bits, write one to clear
  assign irq_event[sdr_pkg::IRQ_XFER] = done;
  assign irq_event[sdr_pkg::IRQ_MODE_FAULT_FLAG] = fault_now & ~mode_fault_flag;
  assign irq_event[sdr_pkg::IRQ_OVR] = overrun_now;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_status <= sdr_pkg::IRQ_RESET;
    end else if (reg_wr & (reg_addr == sdr_pkg::ADDR_IRQ_STATUS)) begin
      irq_status <= irq_event | (irq_status & ~reg_wdata[sdr_pkg::IRQ_W-1:0]);
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_mask <= sdr_pkg::IRQ_RESET;
    end else if (reg_wr & (reg_addr == sdr_pkg::ADDR_IRQ_MASK)) begin
      irq_mask <= reg_wdata[sdr_pkg::IRQ_W-1:0];
    end
  end

  assign irq = (ctrl[sdr_pkg::CTRL_IRQ_EN] & (mode_fault_flag | xfer_done_flag | overrun_flag))
    | (|(irq_status & irq_mask));

  // Read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (sel_data) begin
        reg_rdata <= rx_buf;
      end else if (sel_ctrl) begin
        reg_rdata <= ctrl;
      end else if (sel_csr) begin
        reg_rdata <= {xfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag, 1'b0, csr_cfg};
      end else if (reg_addr == sdr_pkg::ADDR_IRQ_STATUS) begin
        reg_rdata <= {5'h00, irq_status};
      end else if (reg_addr == sdr_pkg::ADDR_IRQ_MASK) begin
        reg_rdata <= {5'h00, irq_mask};
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

//--- hdl/sdr_shift.sv
// Byte shift engine: master clock generation or slave clock edge tracking.
// Assumes pin inputs already synchronised to core_clk by the caller.
`timescale 1ns/1ps
module sdr_shift (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic enable, // Peripheral enabled
  input wire logic master, // Master mode
  input wire logic cpol, // Idle clock level
  input wire logic cpha, // Capture on second edge
  input wire logic [sdr_pkg::RATE_W-1:0] rate, // Master rate code
  input wire logic load, // Accepted data write
  input wire logic [sdr_pkg::DATA_W-1:0] load_data, // Byte to send
  input wire logic sck_sync, // Synchronised serial clock pin
  input wire logic rx_sync, // Synchronised serial data in
  input wire logic selected, // Internal select active
  output logic sck_level, // Serial clock to drive in master mode
  output logic ser_out, // Serial data out
  output logic [sdr_pkg::DATA_W-1:0] rx_byte, // Shift register contents
  output logic busy, // Transfer in progress
  output logic done // One-cycle pulse after last edge
);
  logic [sdr_pkg::DATA_W-1:0] sr;
  logic [sdr_pkg::BIT_CNT_W-1:0] edge_cnt;
  logic [sdr_pkg::HALF_W-1:0] div;
  logic run;
  logic phase;
  logic rbit;
  logic sck_d;
  logic tick;
  logic sck_edge;
  logic edge_evt;
  logic last;
  logic [sdr_pkg::HALF_W-1:0] half;

  assign half = sdr_pkg::half_period(rate);
  assign tick = master & run & (div == half - 7'h01);
  assign sck_edge = ~master & selected & enable & (sck_sync != sck_d);
  assign edge_evt = tick | sck_edge;
  assign last = edge_evt & (edge_cnt == sdr_pkg::LAST_EDGE);
  assign busy = master ? run : (edge_cnt != '0);
  assign sck_level = cpol ^ phase;
  assign ser_out = sr[sdr_pkg::DATA_W-1];
  assign rx_byte = sr;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_sync;
    end
  end

  // Write goes straight into the shift register, no transmit buffer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sr <= '0;
      rbit <= 1'b0;
    end else if (load) begin
      sr <= load_data;
    end else if (edge_evt) begin
      if (cpha & last) begin
        sr <= {sr[sdr_pkg::DATA_W-2:0], rx_sync};
      end else if (edge_cnt[0] == cpha) begin
        rbit <= rx_sync;
      end else if (edge_cnt != '0) begin
        sr <= {sr[sdr_pkg::DATA_W-2:0], rbit};
      end
    end
  end

  // Edge counter restarts whenever the slave is dropped mid-byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      edge_cnt <= '0;
    end else if (~enable | (~master & ~selected) | load) begin
      edge_cnt <= '0;
    end else if (edge_evt) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run <= 1'b0;
      div <= '0;
      phase <= 1'b0;
    end else if (~enable | ~master) begin
      run <= 1'b0;
      div <= '0;
      phase <= 1'b0;
    end else if (load) begin
      run <= 1'b1;
      div <= '0;
      phase <= 1'b0;
    end else if (run) begin
      div <= tick ? '0 : div + 7'h01;
      if (tick) begin
        phase <= ~phase;
      end
      if (last) begin
        run <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= last;
    end
  end
endmodule
